// [common/mac_alu_pkg.sv]
// shared constants for the multiply-accumulate, round, transfer and merge slice
package mac_alu_pkg;
   // register byte offsets on the wishbone bus
   localparam logic [7:0] ADDR_X0 = 8'h00; // x_reg_word0
   localparam logic [7:0] ADDR_X1 = 8'h04; // x_reg_word1
   localparam logic [7:0] ADDR_Y0 = 8'h08; // y_reg_word0
   localparam logic [7:0] ADDR_Y1 = 8'h0c; // y_reg_word1
   localparam logic [7:0] ADDR_A0 = 8'h10; // first accumulator low word
   localparam logic [7:0] ADDR_A1 = 8'h14; // first_acc_middle_word
   localparam logic [7:0] ADDR_A2 = 8'h18; // first accumulator extension byte
   localparam logic [7:0] ADDR_B0 = 8'h1c; // second accumulator low word
   localparam logic [7:0] ADDR_B1 = 8'h20; // second_acc_middle_word
   localparam logic [7:0] ADDR_B2 = 8'h24; // second accumulator extension byte
   localparam logic [7:0] ADDR_IMM = 8'h28; // immediate extension word
   localparam logic [7:0] ADDR_CMD = 8'h2c; // command, a write executes it
   localparam logic [7:0] ADDR_MODE = 8'h30; // rounding and sixteen-bit mode
   localparam logic [7:0] ADDR_STAT = 8'h34; // flags and error, read only
   // command register fields
   localparam int CMD_OP_LSB = 0; // 4-bit operation code
   localparam int CMD_SIGN = 4; // 1 = negate product
   localparam int CMD_DST = 5; // 0 = first acc, 1 = second acc
   localparam int CMD_SRC_LSB = 6; // 3-bit source / first source
   localparam int CMD_SRC2_LSB = 9; // 2-bit second source
   localparam int CMD_N_LSB = 11; // 5-bit scaling exponent
   localparam int CMD_WIDTH = 16;
   // operation codes
   localparam logic [3:0] OP_MAC_IMM = 4'h1; // mac_with_long_immediate
   localparam logic [3:0] OP_MAC_SU = 4'h2; // mac_signed_by_unsigned
   localparam logic [3:0] OP_MAC_UU = 4'h3; // mac_unsigned_by_unsigned
   localparam logic [3:0] OP_MAC_RND = 4'h4; // mac_then_round, register pairs
   localparam logic [3:0] OP_MAC_RND_SCALE = 4'h5; // mac_then_round by 2^-n
   localparam logic [3:0] OP_MAC_RND_IMM = 4'h6; // mac_round_long_immediate
   localparam logic [3:0] OP_SIGNED_MAX = 4'h7; // signed_max_transfer
   localparam logic [3:0] OP_MAG_MAX = 4'h8; // magnitude_max_transfer
   localparam logic [3:0] OP_MERGE = 4'h9; // half-word merge
   // mode register bits and reset value
   localparam int MODE_RND_TWOS = 0; // 1 = two's-complement rounding
   localparam int MODE_SIXTEEN = 1; // sixteen-bit arithmetic mode
   localparam logic [1:0] MODE_RESET = 2'h0;
   // condition code bit positions in the status register
   localparam int CCR_C = 0;
   localparam int CCR_V = 1;
   localparam int CCR_Z = 2;
   localparam int CCR_N = 3;
   localparam int STAT_ERR = 4;
   localparam logic [3:0] CCR_RESET = 4'h0;
   // rounding point and constants
   localparam int RND_POS = 24;
   localparam logic [55:0] RND_HALF = 56'h00000000800000;
   localparam logic [23:0] RND_TIE = 24'h800000;
   // scaling constant is one half shifted right by n-1, i.e. 2^-n
   localparam logic [23:0] SCALE_BASE = 24'h400000;
   localparam logic [4:0] SCALE_N_MIN = 5'h01;
   localparam logic [4:0] SCALE_N_MAX = 5'h17;
   // sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } seq_state_e;
endpackage : mac_alu_pkg

// [rtl/mac_multiplier.sv]
// 24x24 fractional multiplier with per-operand signedness, aligned to 56 bits
`timescale 1ns/1ps
module mac_multiplier (
   input wire logic [23:0] op_a_i, // first operand
   input wire logic [23:0] op_b_i, // second operand
   input wire logic a_signed_i, // first operand is two's complement
   input wire logic b_signed_i, // second operand is two's complement
   output logic [55:0] prod_o // product, binary point after bit 47
);
   logic signed [24:0] ext_a; // operand widened by its sign rule
   logic signed [24:0] ext_b;
   logic signed [49:0] prod; // full product of the widened operands

   // widen each operand so one signed multiply serves all mixes
   always_comb begin
      ext_a = {a_signed_i & op_a_i[23], op_a_i};
      ext_b = {b_signed_i & op_b_i[23], op_b_i};
      prod = ext_a * ext_b;
      // fractional alignment drops the redundant sign bit
      prod_o = {{5{prod[49]}}, prod, 1'b0};
   end
endmodule : mac_multiplier

// [rtl/mac_round_select_merge_alu.sv]
// data-alu slice: immediate, mixed and rounding mac, max transfers, merge
// How it works
// - immediate times source, add/sub to accumulator
// - immediate comes from one 24-bit extension word
// - immediate forms: data registers source, a/b destination
// - minus option negates product; default adds
// - mixed mac: uu or su, any register pairing
// - rounding mac accumulates then rounds into accumulator
// - after rounding low accumulator word is zero
// - scaling round form multiplies by two-to-minus-n
// - register round form takes the eight listed pairs
// - immediate round form accumulates, rounds, clears low
// - signed max: copy first to second if b-a<=0
// - magnitude max: copy if |b| not above |a|
// - carry clear on transfer, set otherwise
// - merge source 11-0 over dest 35-24 into 47-24
// - merge sources: data registers and middle words
// - sixteen-bit mode merges 15-8 with 39-32
// - merge flags: n bit47, z 47-24, v clear
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module mac_round_select_merge_alu (
   input wire logic clk_i, // core clock
   input wire logic rst_i, // synchronous reset, active high
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write enable
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data, registered
   output logic wb_ack_o, // one-cycle acknowledge
   output logic [3:0] ccr_o, // n z v c flags
   output logic busy_o // operation executing
);
   // operand and accumulator state
   logic [23:0] x0_r, x0_nxt; // x_reg_word0
   logic [23:0] x1_r, x1_nxt; // x_reg_word1
   logic [23:0] y0_r, y0_nxt; // y_reg_word0
   logic [23:0] y1_r, y1_nxt; // y_reg_word1
   logic [55:0] a_r, a_nxt; // first accumulator
   logic [55:0] b_r, b_nxt; // second accumulator
   logic [23:0] imm_r, imm_nxt; // extension word
   logic [15:0] cmd_r, cmd_nxt; // latched command
   logic [1:0] mode_r, mode_nxt; // rounding / sixteen-bit mode
   logic [3:0] ccr_r, ccr_nxt; // condition codes
   logic err_r, err_nxt; // last command was illegal
   logic ack_r, ack_nxt; // bus acknowledge
   logic [31:0] dat_r, dat_nxt; // bus read data
   mac_alu_pkg::seq_state_e st_r, st_nxt; // sequencer
   // datapath wires
   logic [31:0] wmask; // byte-lane write mask
   logic req; // new bus request this cycle
   logic [3:0] op; // decoded command fields
   logic [2:0] src;
   logic [1:0] src2;
   logic [4:0] scale_n;
   logic [23:0] mul_a, mul_b; // multiplier operands
   logic a_sgn, b_sgn; // operand signedness
   logic legal; // command fields are allowed
   logic [55:0] prod; // aligned product
   logic [55:0] addend; // product after sign option
   logic [56:0] sum57; // accumulation with carry
   logic [55:0] dst_acc; // selected destination
   logic [55:0] rnd; // rounded accumulation
   logic ovf; // signed overflow of accumulation
   logic [23:0] merge_src; // merge source word
   logic [55:0] merged; // destination after merge
   logic [55:0] mac_res; // accumulation result of a mac form
   logic [56:0] diff; // b - a for signed max
   logic [55:0] mag_a, mag_b; // magnitudes for magnitude max

   // byte-lane mask, one lane per select bit
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
         assign wmask[8*gi +: 8] = {8{wb_sel_i[gi]}};
      end
   endgenerate

   // four-way register pick in the order given by the caller
   function automatic logic [23:0] pick4(input logic [1:0] code, input logic [23:0] r0,
                                         input logic [23:0] r1, input logic [23:0] r2,
                                         input logic [23:0] r3);
      logic [23:0] v;
      case (code)
         2'h0: v = r0;
         2'h1: v = r1;
         2'h2: v = r2;
         default: v = r3;
      endcase
      return v;
   endfunction : pick4

   // merge write data into a register under the byte lanes
   function automatic logic [23:0] lane24(input logic [23:0] old, input logic [31:0] d,
                                          input logic [31:0] m);
      return (old & ~m[23:0]) | (d[23:0] & m[23:0]);
   endfunction : lane24

   mac_multiplier u_mul (
      .op_a_i(mul_a),
      .op_b_i(mul_b),
      .a_signed_i(a_sgn),
      .b_signed_i(b_sgn),
      .prod_o(prod)
   );

   mac_rounder u_rnd (
      .sum_i(sum57[55:0]),
      .convergent_i(~mode_r[mac_alu_pkg::MODE_RND_TWOS]),
      .rnd_o(rnd)
   );

   // operand selection and arithmetic for the latched command
   always_comb begin
      op = cmd_r[mac_alu_pkg::CMD_OP_LSB +: 4];
      src = cmd_r[mac_alu_pkg::CMD_SRC_LSB +: 3];
      src2 = cmd_r[mac_alu_pkg::CMD_SRC2_LSB +: 2];
      scale_n = cmd_r[mac_alu_pkg::CMD_N_LSB +: 5];
      dst_acc = cmd_r[mac_alu_pkg::CMD_DST] ? b_r : a_r;
      mul_a = 24'h000000;
      mul_b = 24'h000000;
      a_sgn = 1'b1;
      b_sgn = 1'b1;
      legal = 1'b1;
      case (op)
         // immediate forms: sources limited to the four data registers
         mac_alu_pkg::OP_MAC_IMM, mac_alu_pkg::OP_MAC_RND_IMM: begin
            mul_a = imm_r;
            mul_b = pick4(src[1:0], x0_r, y0_r, x1_r, y1_r);
            legal = (src[2] == 1'b0);
         end
         // mixed forms: first operand in src, second in src2
         mac_alu_pkg::OP_MAC_SU, mac_alu_pkg::OP_MAC_UU: begin
            mul_a = pick4(src[1:0], x0_r, x1_r, y0_r, y1_r);
            mul_b = pick4(src2, x0_r, x1_r, y0_r, y1_r);
            a_sgn = (op == mac_alu_pkg::OP_MAC_SU);
            b_sgn = 1'b0;
            legal = (src[2] == 1'b0);
         end
         // register round form: eight fixed pairs
         mac_alu_pkg::OP_MAC_RND: begin
            case (src)
               3'h0: begin mul_a = x0_r; mul_b = x0_r; end
               3'h1: begin mul_a = y0_r; mul_b = y0_r; end
               3'h2: begin mul_a = x1_r; mul_b = x0_r; end
               3'h3: begin mul_a = y1_r; mul_b = y0_r; end
               3'h4: begin mul_a = x0_r; mul_b = y1_r; end
               3'h5: begin mul_a = y0_r; mul_b = x0_r; end
               3'h6: begin mul_a = x1_r; mul_b = y0_r; end
               default: begin mul_a = y1_r; mul_b = x1_r; end
            endcase
         end
         // scaling form: multiply by 2^-n, a negative power of two, n outside 1..23 refused
         mac_alu_pkg::OP_MAC_RND_SCALE: begin
            mul_a = pick4(src[1:0], y1_r, x0_r, y0_r, x1_r);
            mul_b = mac_alu_pkg::SCALE_BASE >> (scale_n - 5'h01);
            legal = (src[2] == 1'b0) && (scale_n >= mac_alu_pkg::SCALE_N_MIN)
                    && (scale_n <= mac_alu_pkg::SCALE_N_MAX);
         end
         mac_alu_pkg::OP_SIGNED_MAX, mac_alu_pkg::OP_MAG_MAX: legal = 1'b1;
         mac_alu_pkg::OP_MERGE: legal = (src <= 3'h5);
         default: legal = 1'b0; // unknown operation code
      endcase
      // sign option negates the product before accumulation
      addend = cmd_r[mac_alu_pkg::CMD_SIGN] ? (56'h0 - prod) : prod;
      sum57 = {1'b0, dst_acc} + {1'b0, addend};
      ovf = (dst_acc[55] == addend[55]) && (sum57[55] != dst_acc[55]);
      // merge source: data registers or accumulator middle words
      case (src)
         3'h0: merge_src = x0_r;
         3'h1: merge_src = x1_r;
         3'h2: merge_src = y0_r;
         3'h3: merge_src = y1_r;
         3'h4: merge_src = a_r[47:24];
         default: merge_src = b_r[47:24];
      endcase
      merged = dst_acc;
      if (mode_r[mac_alu_pkg::MODE_SIXTEEN]) begin
         merged[47:32] = {merge_src[15:8], dst_acc[39:32]};
      end else begin
         merged[47:24] = {merge_src[11:0], dst_acc[35:24]};
      end
      // comparisons for the conditional transfers
      diff = {b_r[55], b_r} - {a_r[55], a_r};
      mag_a = a_r[55] ? (56'h0 - a_r) : a_r;
      mag_b = b_r[55] ? (56'h0 - b_r) : b_r;
   end

   // bus slave, command sequencing and result write-back
   always_comb begin
      x0_nxt = x0_r;
      x1_nxt = x1_r;
      y0_nxt = y0_r;
      y1_nxt = y1_r;
      a_nxt = a_r;
      b_nxt = b_r;
      imm_nxt = imm_r;
      cmd_nxt = cmd_r;
      mode_nxt = mode_r;
      ccr_nxt = ccr_r;
      err_nxt = err_r;
      st_nxt = st_r;
      dat_nxt = dat_r;
      mac_res = sum57[55:0];
      // accesses wait while a command executes, so no write races the result
      req = wb_cyc_i && wb_stb_i && !ack_r && (st_r == mac_alu_pkg::ST_IDLE);
      ack_nxt = req;
      if (req && wb_we_i) begin
         // unmapped writes are acknowledged and dropped
         if (wb_adr_i == mac_alu_pkg::ADDR_X0) begin
            x0_nxt = lane24(x0_r, wb_dat_i, wmask);
         end else if (wb_adr_i == mac_alu_pkg::ADDR_X1) begin
            x1_nxt = lane24(x1_r, wb_dat_i, wmask);
         end else if (wb_adr_i == mac_alu_pkg::ADDR_Y0) begin
            y0_nxt = lane24(y0_r, wb_dat_i, wmask);
         end else if (wb_adr_i == mac_alu_pkg::ADDR_Y1) begin
            y1_nxt = lane24(y1_r, wb_dat_i, wmask);
         end else if (wb_adr_i == mac_alu_pkg::ADDR_A0) begin
            a_nxt[23:0] = lane24(a_r[23:0], wb_dat_i, wmask);
         end else if (wb_adr_i == mac_alu_pkg::ADDR_A1) begin
            a_nxt[47:24] = lane24(a_r[47:24], wb_dat_i, wmask);
         end else if (wb_adr_i == mac_alu_pkg::ADDR_A2) begin
            if (wb_sel_i[0]) a_nxt[55:48] = wb_dat_i[7:0];
         end else if (wb_adr_i == mac_alu_pkg::ADDR_B0) begin
            b_nxt[23:0] = lane24(b_r[23:0], wb_dat_i, wmask);
         end else if (wb_adr_i == mac_alu_pkg::ADDR_B1) begin
            b_nxt[47:24] = lane24(b_r[47:24], wb_dat_i, wmask);
         end else if (wb_adr_i == mac_alu_pkg::ADDR_B2) begin
            if (wb_sel_i[0]) b_nxt[55:48] = wb_dat_i[7:0];
         end else if (wb_adr_i == mac_alu_pkg::ADDR_IMM) begin
            imm_nxt = lane24(imm_r, wb_dat_i, wmask);
         end else if (wb_adr_i == mac_alu_pkg::ADDR_CMD) begin
            // a command write always executes the whole word
            cmd_nxt = wb_dat_i[15:0];
            st_nxt = mac_alu_pkg::ST_EXEC;
         end else if (wb_adr_i == mac_alu_pkg::ADDR_MODE) begin
            if (wb_sel_i[0]) mode_nxt = wb_dat_i[1:0];
         end
      end else if (req) begin
         // reads: narrow registers sit in the low bits, upper bits zero
         if (wb_adr_i == mac_alu_pkg::ADDR_X0) begin
            dat_nxt = {8'h00, x0_r};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_X1) begin
            dat_nxt = {8'h00, x1_r};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_Y0) begin
            dat_nxt = {8'h00, y0_r};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_Y1) begin
            dat_nxt = {8'h00, y1_r};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_A0) begin
            dat_nxt = {8'h00, a_r[23:0]};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_A1) begin
            dat_nxt = {8'h00, a_r[47:24]};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_A2) begin
            dat_nxt = {24'h000000, a_r[55:48]};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_B0) begin
            dat_nxt = {8'h00, b_r[23:0]};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_B1) begin
            dat_nxt = {8'h00, b_r[47:24]};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_B2) begin
            dat_nxt = {24'h000000, b_r[55:48]};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_IMM) begin
            dat_nxt = {8'h00, imm_r};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_CMD) begin
            dat_nxt = {16'h0000, cmd_r};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_MODE) begin
            dat_nxt = {30'h00000000, mode_r};
         end else if (wb_adr_i == mac_alu_pkg::ADDR_STAT) begin
            dat_nxt = {27'h0000000, err_r, ccr_r};
         end else begin
            dat_nxt = 32'h00000000; // unmapped reads as zero
         end
      end
      case (st_r)
         mac_alu_pkg::ST_EXEC: begin
            st_nxt = mac_alu_pkg::ST_IDLE;
            err_nxt = !legal;
            if (legal) begin
               case (op)
                  mac_alu_pkg::OP_MAC_IMM, mac_alu_pkg::OP_MAC_SU,
                  mac_alu_pkg::OP_MAC_UU, mac_alu_pkg::OP_MAC_RND,
                  mac_alu_pkg::OP_MAC_RND_SCALE, mac_alu_pkg::OP_MAC_RND_IMM: begin
                     // round ops keep only the rounded upper part
                     if (op == mac_alu_pkg::OP_MAC_RND || op == mac_alu_pkg::OP_MAC_RND_SCALE
                         || op == mac_alu_pkg::OP_MAC_RND_IMM) begin
                        mac_res = rnd;
                     end
                     if (cmd_r[mac_alu_pkg::CMD_DST]) b_nxt = mac_res;
                     else a_nxt = mac_res;
                     ccr_nxt[mac_alu_pkg::CCR_N] = mac_res[55];
                     ccr_nxt[mac_alu_pkg::CCR_Z] = (mac_res == 56'h0);
                     ccr_nxt[mac_alu_pkg::CCR_V] = ovf;
                     ccr_nxt[mac_alu_pkg::CCR_C] = sum57[56];
                  end
                  mac_alu_pkg::OP_SIGNED_MAX: begin
                     if (diff[56] || diff == 57'h0) begin
                        b_nxt = a_r;
                        ccr_nxt[mac_alu_pkg::CCR_C] = 1'b0;
                     end else begin
                        ccr_nxt[mac_alu_pkg::CCR_C] = 1'b1;
                     end
                  end
                  mac_alu_pkg::OP_MAG_MAX: begin
                     if (mag_b <= mag_a) begin
                        b_nxt = a_r;
                        ccr_nxt[mac_alu_pkg::CCR_C] = 1'b0;
                     end else begin
                        ccr_nxt[mac_alu_pkg::CCR_C] = 1'b1;
                     end
                  end
                  default: begin
                     // merge: only bits 47-24 (or 47-32) change
                     if (cmd_r[mac_alu_pkg::CMD_DST]) b_nxt = merged;
                     else a_nxt = merged;
                     ccr_nxt[mac_alu_pkg::CCR_N] = merged[47];
                     ccr_nxt[mac_alu_pkg::CCR_Z] = (merged[47:24] == 24'h000000);
                     ccr_nxt[mac_alu_pkg::CCR_V] = 1'b0;
                  end
               endcase
            end
         end
         default: st_nxt = st_nxt; // idle: wait for a command write
      endcase
   end

   // register all state; reset gives every control bit a defined value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         x0_r <= 24'h000000;
         x1_r <= 24'h000000;
         y0_r <= 24'h000000;
         y1_r <= 24'h000000;
         a_r <= 56'h0;
         b_r <= 56'h0;
         imm_r <= 24'h000000;
         cmd_r <= 16'h0000;
         mode_r <= mac_alu_pkg::MODE_RESET;
         ccr_r <= mac_alu_pkg::CCR_RESET;
         err_r <= 1'b0;
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
         st_r <= mac_alu_pkg::ST_IDLE;
      end else begin
         x0_r <= x0_nxt;
         x1_r <= x1_nxt;
         y0_r <= y0_nxt;
         y1_r <= y1_nxt;
         a_r <= a_nxt;
         b_r <= b_nxt;
         imm_r <= imm_nxt;
         cmd_r <= cmd_nxt;
         mode_r <= mode_nxt;
         ccr_r <= ccr_nxt;
         err_r <= err_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         st_r <= st_nxt;
      end
   end

   // outputs are register bits only
   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;
   assign ccr_o = ccr_r;
   assign busy_o = st_r[1];
endmodule : mac_round_select_merge_alu

// [rtl/mac_rounder.sv]
// rounds a 56-bit accumulator value at bit 24 and clears the low word
`timescale 1ns/1ps
module mac_rounder (
   input wire logic [55:0] sum_i, // unrounded accumulation
   input wire logic convergent_i, // 1 = convergent, 0 = two's complement
   output logic [55:0] rnd_o // rounded value, low word zero
);
   logic [55:0] biased; // sum plus one half of the rounding lsb
   logic [31:0] upper; // rounded upper portion
   logic tie; // low word exactly one half

   // add one half, then force even on an exact tie in convergent mode
   always_comb begin
      biased = sum_i + mac_alu_pkg::RND_HALF;
      tie = (sum_i[23:0] == mac_alu_pkg::RND_TIE);
      upper = biased[55:mac_alu_pkg::RND_POS];
      if (convergent_i && tie) begin
         upper[0] = 1'b0; // unbiased: ties go to even
      end
      rnd_o = {upper, 24'h000000};
   end
endmodule : mac_rounder

// [tb/core_seq_model.sv]
// wishbone master standing in for the core sequencer
`timescale 1ns/1ps
module core_seq_model (
   input wire logic clk_i, // core clock
   input wire logic rst_i, // reset
   input wire logic go_i, // start one transfer
   input wire logic we_i, // write request
   input wire logic [7:0] adr_i, // address
   input wire logic [31:0] dat_i, // write data
   input wire logic ack_i, // slave ack
   input wire logic [31:0] rd_i, // slave read data
   output logic cyc_o, // cyc and stb
   output logic we_o, // direction
   output logic [7:0] adr_o, // address
   output logic [31:0] dat_o, // write data
   output logic [31:0] rdat_o, // captured read data
   output logic done_o // one-cycle end pulse
);
   // released lines flip so a stale value never looks valid
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      if (rst_i) begin
         cyc_o <= 1'b0;
      end else if (cyc_o && ack_i) begin
         cyc_o <= 1'b0;
         done_o <= 1'b1;
         rdat_o <= rd_i;
         adr_o <= ~adr_o;
         dat_o <= ~dat_o;
      end else if (!cyc_o && go_i && !done_o) begin
         cyc_o <= 1'b1;
         we_o <= we_i;
         adr_o <= adr_i;
         dat_o <= dat_i;
      end
   end
endmodule : core_seq_model

// [tb/mac_alu_assertions.sv]
// port assertions for the mac alu slice
`timescale 1ns/1ps
module mac_alu_checker (
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [7:0] wb_adr_i, // address
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic wb_ack_o, // ack
   input wire logic [3:0] ccr_o, // flags
   input wire logic busy_o // busy
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // command write taken at this edge
   wire take = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & !busy_o
      & (wb_adr_i == mac_alu_pkg::ADDR_CMD);
   wire mrg = take && wb_dat_i[3:0] == mac_alu_pkg::OP_MERGE && wb_dat_i[8:6] < 3'h6;
   wire mx = take && (wb_dat_i[3:0] == mac_alu_pkg::OP_SIGNED_MAX
      || wb_dat_i[3:0] == mac_alu_pkg::OP_MAG_MAX);
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   AST_ACK_REQ: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   AST_CMD_BUSY: assert property (take |=> busy_o && wb_ack_o) else $error("no busy");
   AST_BUSY_ONE: assert property (busy_o |=> !busy_o) else $error("busy too long");
   AST_CCR_HOLD: assert property (!busy_o |=> $stable(ccr_o)) else $error("flags moved");
   AST_MAX_FLAGS: assert property (mx |-> ##2 ccr_o[3:1] == $past(ccr_o[3:1], 2))
      else $error("max touched nzv");
   AST_MERGE_V: assert property (mrg |-> ##2 !ccr_o[1]) else $error("v set");
   AST_MERGE_C: assert property (mrg |-> ##2 ccr_o[0] == $past(ccr_o[0], 2))
      else $error("merge touched c");
   // main scenarios reached
   COV_MERGE: cover property (mrg);
   COV_MAX: cover property (mx);
   COV_CMD: cover property (take);
endmodule : mac_alu_checker
bind mac_round_select_merge_alu mac_alu_checker mac_alu_checker_i (.clk_i(clk_i),
   .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .ccr_o(ccr_o),
   .busy_o(busy_o));

// [tb/tb_mac_round_select_merge_alu.sv]
// self-checking bench for the mac alu slice
`timescale 1ns/1ps
module tb_mac_round_select_merge_alu;
   logic clk_i = 1'b0; // core clock
   logic rst_i = 1'b1; // reset
   logic go = 1'b0; // transfer request
   logic we = 1'b0; // direction
   logic [7:0] adr = 8'h00; // address
   logic [31:0] wd = 32'h0; // write data
   logic cyc, mwe, ack, busy, done;
   logic [7:0] madr;
   logic [31:0] mdat, rdat, dato;
   logic [3:0] ccr;
   int fails = 0;
   int checked = 0;
   always #25 clk_i = ~clk_i;
   mac_round_select_merge_alu mac_round_select_merge_alu_i (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(mwe), .wb_adr_i(madr), .wb_sel_i(4'hf),
      .wb_dat_i(mdat), .wb_dat_o(dato), .wb_ack_o(ack), .ccr_o(ccr), .busy_o(busy));
   core_seq_model core_seq_model_i (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .we_i(we),
      .adr_i(adr), .dat_i(wd), .ack_i(ack), .rd_i(dato), .cyc_o(cyc), .we_o(mwe),
      .adr_o(madr), .dat_o(mdat), .rdat_o(rdat), .done_o(done));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one bus cycle; the model holds the request until ack
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      go <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      @(posedge clk_i);
      while (!done) @(posedge clk_i);
      go <= 1'b0;
   endtask : xfer
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask : rd
   task automatic cmd(input logic [31:0] c, input logic [3:0] f);
      xfer(1'b1, mac_alu_pkg::ADDR_CMD, c);
      chk({28'h0, ccr}, {28'h0, f});
   endtask : cmd
   task automatic t_reset();
      chk({30'h0, busy, ccr[0]}, 32'h0);
      rd(8'h3c, 32'h0); // unmapped reads zero
   endtask : t_reset
   // 0 - 0.5*0.25 leaves ff f00000 000000
   task automatic t_mac_imm();
      xfer(1'b1, mac_alu_pkg::ADDR_X0, 32'h400000);
      xfer(1'b1, mac_alu_pkg::ADDR_IMM, 32'h200000);
      cmd(32'h0011, 4'h8);
      rd(mac_alu_pkg::ADDR_A1, 32'hf00000);
      rd(mac_alu_pkg::ADDR_A2, 32'hff);
   endtask : t_mac_imm
   // no transfer, transfer, then magnitude beats sign
   task automatic t_max();
      xfer(1'b1, mac_alu_pkg::ADDR_B1, 32'h100000);
      cmd(32'h0007, 4'h9);
      rd(mac_alu_pkg::ADDR_B1, 32'h100000);
      xfer(1'b1, mac_alu_pkg::ADDR_A2, 32'h0);
      xfer(1'b1, mac_alu_pkg::ADDR_A1, 32'h300000);
      cmd(32'h0007, 4'h8);
      rd(mac_alu_pkg::ADDR_B1, 32'h300000);
      xfer(1'b1, mac_alu_pkg::ADDR_A2, 32'hff);
      xfer(1'b1, mac_alu_pkg::ADDR_A1, 32'hc00000);
      cmd(32'h0008, 4'h8);
      rd(mac_alu_pkg::ADDR_B2, 32'hff);
   endtask : t_max
   // normal then sixteen-bit merge into the first accumulator
   task automatic t_merge();
      xfer(1'b1, mac_alu_pkg::ADDR_X1, 32'h000abc);
      cmd(32'h0049, 4'h8);
      rd(mac_alu_pkg::ADDR_A1, 32'habc000);
      rd(mac_alu_pkg::ADDR_A2, 32'hff);
      xfer(1'b1, mac_alu_pkg::ADDR_Y0, 32'h001200);
      xfer(1'b1, mac_alu_pkg::ADDR_MODE, 32'h2);
      cmd(32'h0089, 4'h0);
      rd(mac_alu_pkg::ADDR_A1, 32'h12c000);
   endtask : t_merge
   // tie to even, tie up in two's mode, then scaled mac
   task automatic t_round();
      xfer(1'b1, mac_alu_pkg::ADDR_B2, 32'h0);
      xfer(1'b1, mac_alu_pkg::ADDR_B1, 32'h2);
      xfer(1'b1, mac_alu_pkg::ADDR_B0, 32'h800000);
      cmd(32'h00e4, 4'h0);
      rd(mac_alu_pkg::ADDR_B1, 32'h2);
      rd(mac_alu_pkg::ADDR_B0, 32'h0);
      xfer(1'b1, mac_alu_pkg::ADDR_MODE, 32'h1);
      xfer(1'b1, mac_alu_pkg::ADDR_B0, 32'h800000);
      cmd(32'h00e4, 4'h0);
      rd(mac_alu_pkg::ADDR_B1, 32'h3);
      cmd(32'h0865, 4'h0);
      rd(mac_alu_pkg::ADDR_B1, 32'h200003);
   endtask : t_round
   task automatic end_of_test();
      if (fails == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_mac_imm();
      t_max();
      t_merge();
      t_round();
      end_of_test();
   end
   // hang guard, far beyond the few hundred cycles needed
   initial begin
      repeat (5000) @(posedge clk_i);
      fails++;
      end_of_test();
   end
endmodule : tb_mac_round_select_merge_alu
